/* File: sccfg_pkg.sv */
package sccfg_pkg;
    // ------------------------------------------------------------
    // register map and widths
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_ZERO_OFS = 12'h108; // channel_config_zero
    localparam logic [11:0] CFG_ONE_OFS  = 12'h10c; // channel_config_one
    localparam logic [11:0] STAT_OFS     = 12'h114; // pin and run status
    localparam logic [11:0] IRQ_STAT_OFS = 12'h118; // interrupt_status_reg
    localparam logic [11:0] IRQ_MASK_OFS = 12'h11c; // 1 masks a source
    localparam logic [31:0] CFG_RST      = 32'h0000_0000;
    localparam logic [7:0]  IRQ_RST      = 8'h00;
    localparam int          IRQ_W        = 8;
    // channel_config_zero fields
    localparam int Z_VIS = 12, Z_PSD = 8, Z_BCR = 7, Z_TOE = 5;
    localparam int Z_SSEL = 4, Z_HS = 3, Z_CM = 0, Z_SC = 16, Z_SM = 20;
    localparam logic [31:0] Z_WMASK = 32'h0037_11bf;
    // channel_config_one fields
    localparam int O_DIV = 25, O_TX_CLOCK_ON_REQUEST_PIN = 24, O_SOC = 22, O_RTS = 21;
    localparam int O_REQUEST_FLOW_CONTROL = 20, O_CLEAR_FLOW_CONTROL = 19, O_CAS = 18, O_ICD = 17;
    localparam int O_ODS = 16;
    localparam logic [31:0] O_WMASK = 32'h03ff_0000;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCC_NRZ = 3'h0, SCC_BUS1 = 3'h1, SCC_NRZI = 3'h2, SCC_BUS2 = 3'h3,
        SCC_FM0 = 3'h4, SCC_FM1 = 3'h5, SCC_MAN = 3'h6, SCC_RSVD = 3'h7
    } sccfg_code_e;
    typedef enum logic [1:0] {
        SCC_HDLC = 2'h0, SCC_ENG_RSVD = 2'h1, SCC_BISYNC = 2'h2, SCC_ASYNC = 2'h3
    } sccfg_eng_e;
    localparam logic [2:0] CM_HS   = 3'h4; // high-speed clock mode
    localparam logic [2:0] CM_SLOT = 3'h5; // time-slot clock mode

    // ------------------------------------------------------------
    // whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]      cfg0;
        logic [31:0]      cfg1;
        logic [IRQ_W-1:0] interrupt_status_reg;
        logic [IRQ_W-1:0] imask;
        logic [31:0]      prdata;
        logic             pslverr;
        logic [1:0]       cts_s;
        logic [1:0]       cd_s;
        logic [2:0]       tclk_s;
        logic [1:0]       rxd_s;
        logic             rts_n;
        logic             tx_run;
        logic             txd;
        logic             txd_oe_n;
        logic             rxd;
        logic             vec;
    } sccfg_state_s;
endpackage

/* File: sccfg_top.sv */
`timescale 1ns/1ps
// Function
// (RQ1) line coding chosen by three-bit field
// (RQ2) bus configuration modes use NRZ only
// (RQ3) two-bit field picks protocol engine
// (RQ4) masked status visible and read-cleared when enabled
// (RQ5) masked sources never raise a vector
// (RQ6) phase shift off, wide windows for NRZ/NRZI
// (RQ7) bit clock rate picks 1x or 16x voting
// (RQ8) tx clock pin drives clock or slot marker
// (RQ9) clock source bit picks option a or b
// (RQ10) high speed bit switches paths, gates clocks
// (RQ11) clock mode field selects modes 0 to 7
// (RQ12) bus modes drive request pin per output control
// (RQ13) data inversion on NRZ inverts every bit except HDLC idle ones
// (RQ14) idle ones stay uninverted in HDLC
// (RQ15) driver bit: open drain or push pull
// (RQ16) carrier polarity bit inverts carrier input
// (RQ17) high speed: tx clock on request pin
// (RQ18) HDLC request pin automatic or software held
// (RQ19) async/bisync request pin forced or FIFO driven
// (RQ20) request flow follows receive FIFO level
// (RQ21) clear-to-send stops transmitter unless ignored
// (RQ22) character modes finish current byte
// (RQ23) carrier auto start gates receiver
// (RQ24) software keeps auto start off in modes 1,4,5
module sccfg_top
    import sccfg_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // protocol engine side
    input  wire logic             tx_active,
    input  wire logic             rx_active,
    input  wire logic             tx_fifo_has_data,
    input  wire logic             rx_shadow_empty,
    input  wire logic             rx_at_threshold,
    input  wire logic             byte_in_progress,
    input  wire logic             async_ppp_mode,
    input  wire logic             tx_idle_ones,
    input  wire logic             tx_bit,
    input  wire logic             tx_clk_int,
    input  wire logic             tx_slot_mark,
    input  wire logic [IRQ_W-1:0] irq_events,
    output sccfg_code_e           line_coding_select,
    output sccfg_eng_e            protocol_engine_select,
    output logic [2:0]            clock_mode_select,
    output logic                  bus_config_mode,
    output logic                  clk_option_b,
    output logic                  dpll_no_shift,
    output logic                  sample_x16,
    output logic                  high_speed_path,
    output logic                  tx_enable,
    output logic                  rx_enable,
    output logic                  rx_bit,
    output logic                  cd_level,
    output logic                  irq_vector,
    // serial pins
    input  wire logic             cts_n_pin,
    input  wire logic             cd_pin,
    input  wire logic             rxd_pin,
    input  wire logic             tx_clock_pin_in,
    output logic                  tx_clock_pin_out,
    output logic                  tx_clock_pin_oe_n,
    output logic                  rts_n_pin_out,
    output logic                  rts_n_pin_oe_n,
    output logic                  txd_pin_out,
    output logic                  txd_pin_oe_n
);
    import sccfg_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // nrz-type codings, bus modes included
    function automatic logic is_nrz(input logic [2:0] sc);
        return (sc == SCC_NRZ) || (sc == SCC_BUS1) || (sc == SCC_BUS2);
    endfunction

    // clock modes with an a/b option
    function automatic logic has_opt(input logic [2:0] cm);
        return (cm == 3'h0) || (cm == 3'h2) || (cm == 3'h3) || (cm >= 3'h6);
    endfunction

    sccfg_state_s q, d;             // registered state and next value
    logic         wr_en;            // write completes this edge
    logic         rd_en;            // read completes this edge
    logic         setup;            // apb setup phase
    logic [IRQ_W-1:0] vis_bits;     // bits a status read returns
    logic         hdlc, async_m, char_m;
    logic         hs_on, tclk_rise;
    logic         cts_act, cd_act;
    logic         rts_want_n;       // request level before hs override
    logic         inv;              // data inversion active
    logic         txd_val;

    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    assign line_coding_select     = sccfg_code_e'(q.cfg0[Z_SC +: 3]); // [RQ1]
    assign protocol_engine_select = sccfg_eng_e'(q.cfg0[Z_SM +: 2]);  // [RQ3]
    assign clock_mode_select      = q.cfg0[Z_CM +: 3];                // [RQ11]
    // bus modes carry nrz timing only
    assign bus_config_mode = (line_coding_select == SCC_BUS1) ||
                             (line_coding_select == SCC_BUS2);        // [RQ2]
    assign hdlc    = (protocol_engine_select == SCC_HDLC);
    assign async_m = (protocol_engine_select == SCC_ASYNC);
    // character oriented engines finish a byte once started
    assign char_m  = async_m || (protocol_engine_select == SCC_BISYNC) ||
                     (hdlc && async_ppp_mode);
    assign hs_on   = hdlc && q.cfg0[Z_HS] && (clock_mode_select == CM_HS);
    assign clk_option_b = q.cfg0[Z_SSEL] && has_opt(clock_mode_select); // [RQ9]
    assign dpll_no_shift = q.cfg0[Z_PSD] &&
        (is_nrz(line_coding_select) || line_coding_select == SCC_NRZI); // [RQ6]
    // 16x voting only without dpll: modes 0, 1, 3b, 7b
    assign sample_x16 = q.cfg0[Z_BCR] && (async_m || (hdlc && async_ppp_mode)) &&
        ((clock_mode_select <= 3'h1) ||
         (q.cfg0[Z_SSEL] && (clock_mode_select == 3'h3 ||
                             clock_mode_select == 3'h7)));          // [RQ7]
    assign high_speed_path = hdlc && q.cfg0[Z_HS];                 // [RQ10]
    assign inv = q.cfg1[O_DIV] && is_nrz(line_coding_select);      // [RQ13]

    // ------------------------------------------------------------
    // pin levels after synchronisers
    // ------------------------------------------------------------
    assign cts_act   = ~q.cts_s[1];
    assign cd_act    = q.cd_s[1] ^ q.cfg1[O_ICD];                  // [RQ16]
    assign cd_level  = q.cd_s[1];
    assign tclk_rise = q.tclk_s[1] && !q.tclk_s[2];
    // auto start off means always on; software keeps it off in 1,4,5
    assign rx_enable = q.cfg1[O_CAS] ? cd_act : 1'b1;              // [RQ23] [RQ24]
    assign tx_enable = q.tx_run;
    assign rx_bit    = q.rxd;
    assign irq_vector = q.vec;

    // ------------------------------------------------------------
    // request line choice
    // ------------------------------------------------------------
    always_comb
    begin
        rts_want_n = 1'b1;
        if (hdlc && bus_config_mode && !q.cfg1[O_RTS])
        begin
            // output control field owns the pin in bus modes
            unique case (q.cfg1[O_SOC +: 2])
                2'h2:    rts_want_n = 1'b1;                        // [RQ12]
                2'h3:    rts_want_n = !rx_active;                  // [RQ12]
                default: rts_want_n = !tx_active;                  // [RQ12]
            endcase
        end
        else if (hdlc)
        begin
            // software hold keeps it low until cleared
            rts_want_n = !(q.cfg1[O_RTS] || tx_active);            // [RQ18]
        end
        else if (q.cfg1[O_RTS])
        begin
            rts_want_n = q.cfg1[O_REQUEST_FLOW_CONTROL];                           // [RQ19]
        end
        else if (q.cfg1[O_REQUEST_FLOW_CONTROL])
        begin
            // low when shadow empty, high at threshold, else hold
            if (rx_at_threshold)
                rts_want_n = 1'b1;                                 // [RQ20]
            else if (rx_shadow_empty)
                rts_want_n = 1'b0;                                 // [RQ20]
            else
                rts_want_n = q.rts_n;
        end
        else
        begin
            rts_want_n = !tx_fifo_has_data;                        // [RQ19]
        end
    end

    // ------------------------------------------------------------
    // pins driven out
    // ------------------------------------------------------------
    always_comb
    begin
        // in hs mode the request pin is a clock or an unused input
        rts_n_pin_out  = (hs_on && q.cfg1[O_TX_CLOCK_ON_REQUEST_PIN]) ? tx_clk_int : q.rts_n; // [RQ17]
        rts_n_pin_oe_n = hs_on && !q.cfg1[O_TX_CLOCK_ON_REQUEST_PIN];                // [RQ17]
        tx_clock_pin_out  = tx_clk_int;
        tx_clock_pin_oe_n = 1'b1;
        if (q.cfg0[Z_TOE])
        begin
            if (clock_mode_select == CM_SLOT)
            begin
                tx_clock_pin_out  = tx_slot_mark;                  // [RQ8]
                tx_clock_pin_oe_n = 1'b0;
            end
            else if (q.cfg0[Z_SSEL] ? has_opt(clock_mode_select)
                     : (clock_mode_select == 3'h3 || clock_mode_select == 3'h7))
            begin
                tx_clock_pin_oe_n = 1'b0;                          // [RQ8]
            end
        end
    end
    assign txd_pin_out  = q.txd;
    assign txd_pin_oe_n = q.txd_oe_n;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup  = psel && !penable;
    assign pready = 1'b1;           // zero wait: data captured in setup
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr && psel && penable;
    // masked bits show only when visible
    assign vis_bits = q.cfg0[Z_VIS] ? q.interrupt_status_reg : (q.interrupt_status_reg & ~q.imask);  // [RQ4]
    assign txd_val = tx_bit ^ (inv && !(hdlc && tx_idle_ones));    // [RQ13] [RQ14]

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        // synchronisers, first stage read only by second
        d.cts_s  = {q.cts_s[0], cts_n_pin};
        d.cd_s   = {q.cd_s[0], cd_pin};
        d.rxd_s  = {q.rxd_s[0], rxd_pin};
        d.tclk_s = {q.tclk_s[1:0], tx_clock_pin_in};
        d.rxd    = q.rxd_s[1] ^ inv;                               // [RQ13]
        // captured read data for the access phase
        if (setup)
        begin
            d.pslverr = 1'b0;
            unique case (paddr)
                CFG_ZERO_OFS: d.prdata = q.cfg0;
                CFG_ONE_OFS:  d.prdata = q.cfg1;
                STAT_OFS:     d.prdata = {26'h0, !q.rts_n, rx_enable,
                                          q.tx_run, cd_act, cts_act, hs_on};
                IRQ_STAT_OFS: d.prdata = {24'h0, vis_bits};
                IRQ_MASK_OFS: d.prdata = {24'h0, q.imask};
                default:
                begin
                    d.prdata  = 32'h0;
                    d.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_en)
        begin
            if (paddr == CFG_ZERO_OFS)
                d.cfg0 = pwdata & Z_WMASK;
            if (paddr == CFG_ONE_OFS)
                d.cfg1 = pwdata & O_WMASK;
            if (paddr == IRQ_MASK_OFS)
                d.imask = pwdata[IRQ_W-1:0];
        end
        // read clears only what setup captured and returned; an event that
        // lands between setup and access stays pending, new events win
        if (rd_en && paddr == IRQ_STAT_OFS)
            d.interrupt_status_reg = q.interrupt_status_reg & ~q.prdata[IRQ_W-1:0];                  // [RQ4]
        d.interrupt_status_reg = d.interrupt_status_reg | irq_events;
        // vector only for unmasked sources
        d.vec = |(irq_events & ~q.imask);                          // [RQ5]
        // transmitter gating by clear-to-send
        d.tx_run = q.cfg1[O_CLEAR_FLOW_CONTROL] || cts_act ||
                   (char_m && byte_in_progress && q.tx_run);       // [RQ21] [RQ22]
        if (hs_on)
            d.tx_run = 1'b1;
        // request pin follows the transmit clock
        if (tclk_rise || hs_on)
            d.rts_n = rts_want_n;
        // open drain drives only the low level
        d.txd      = txd_val;
        d.txd_oe_n = !(q.cfg1[O_ODS] || !txd_val);                 // [RQ15]
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            q          <= '0;
            q.cfg0     <= CFG_RST;
            q.cfg1     <= CFG_RST;
            q.interrupt_status_reg      <= IRQ_RST;
            q.imask    <= IRQ_RST;
            q.rts_n    <= 1'b1;
            q.txd      <= 1'b1;
            q.txd_oe_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    vec_masked_a: assert property ( // [RQ5]
        (irq_events & q.imask) == irq_events |=> !irq_vector)
        else $error("masked source raised vector");
    isr_sticky_a: assert property ( // [RQ4]
        irq_events[0] |=> q.interrupt_status_reg[0])
        else $error("event lost in status");
    isr_hidden_a: assert property ( // [RQ4]
        setup && paddr == IRQ_STAT_OFS && !q.cfg0[Z_VIS] && q.imask[0]
        |=> !prdata[0])
        else $error("masked bit visible");
    tx_stop_a: assert property ( // [RQ21]
        !q.cfg1[O_CLEAR_FLOW_CONTROL] && !cts_act && !char_m && !hs_on |=> !tx_enable)
        else $error("tx ran with cts inactive");
    tx_byte_a: assert property ( // [RQ22]
        tx_enable && char_m && byte_in_progress && !reset |=> tx_enable)
        else $error("byte cut short");
    txd_od_a: assert property ( // [RQ15]
        !q.cfg1[O_ODS] |=> txd_pin_oe_n || !txd_pin_out)
        else $error("open drain drove high");
    rx_gate_a: assert property ( // [RQ23]
        q.cfg1[O_CAS] |-> rx_enable == (q.cd_s[1] ^ q.cfg1[O_ICD]))
        else $error("receiver not gated by carrier");
    rts_hs_a: assert property ( // [RQ17]
        hs_on && !q.cfg1[O_TX_CLOCK_ON_REQUEST_PIN] |-> rts_n_pin_oe_n)
        else $error("request pin driven in hs");
    rts_force_a: assert property ( // [RQ19]
        !hdlc && q.cfg1[O_RTS] && tclk_rise |=> rts_n_pin_out == $past(q.cfg1[O_REQUEST_FLOW_CONTROL]))
        else $error("forced request level wrong");
    div_tx_a: assert property ( // [RQ13]
        inv && !hdlc |=> txd_pin_out == !$past(tx_bit))
        else $error("tx data not inverted");

    rd_isr_c: cover property (rd_en && paddr == IRQ_STAT_OFS && |prdata);
    cts_stop_c: cover property (tx_enable ##1 !tx_enable);
    hs_clk_c: cover property (hs_on && q.cfg1[O_TX_CLOCK_ON_REQUEST_PIN]);
endmodule

/* File: sccfg_remote.sv */
`timescale 1ns/1ps
// ----------------------------------------
// remote station and modem lines
// ----------------------------------------
module sccfg_remote (
    // levels asked for by the bench
    input  wire logic run,
    input  wire logic cts_n,
    input  wire logic cd,
    input  wire logic rxd,
    // device side pins
    input  wire logic txd_out,
    input  wire logic txd_oe_n,
    output logic      cts_n_pin,
    output logic      cd_pin,
    output logic      rxd_pin,
    output logic      tclk,
    output logic      line
);
    // 64 ns link clock, odd phase; stands low between frames
    initial
    begin
        tclk = 1'b0;
        #3;
        forever
        begin
            #32;
            tclk = run ? ~tclk : 1'b0;
        end
    end
    // pull-up on the line, so a released open drain reads high
    assign line      = txd_oe_n ? 1'b1 : txd_out;
    // modem levels go straight to the pins
    assign cts_n_pin = cts_n;
    assign cd_pin    = cd;
    assign rxd_pin   = rxd;
endmodule

/* File: serial_channel_config_tb.sv */
`timescale 1ns/1ps
module serial_channel_config_tb;
    import sccfg_pkg::*;
    // ----------------------------------------
    // bench signals
    // ----------------------------------------
    logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, v, c;
    logic        tx_act, rx_act, fifo, sh_empty, at_thr, byte_ip, ppp;
    logic        idle1, tx_bit, tclk_int, slot, busm, optb, noshift, x16, hsp;
    logic        tx_en, rx_en, rx_bit, cdl, vec, run, cts_n, cd, rxd;
    logic        cts_pin, cd_pin, rxd_pin, tclk, line;
    logic        tco, tco_oe_n, rts_o, rts_oe_n, txd_o, txd_oe_n;
    logic [7:0]  irq_ev;
    logic [1:0]  eng_tab [3] = '{2'h0, 2'h2, 2'h3}; // legal engines only
    sccfg_code_e lcs;
    sccfg_eng_e  pes;
    logic [2:0]  cms;
    int          bad_count, n_checks, seed, i;
    int          cyc = 0;

    sccfg_top dut (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_active(tx_act),
        .rx_active(rx_act), .tx_fifo_has_data(fifo), .rx_shadow_empty(sh_empty),
        .rx_at_threshold(at_thr), .byte_in_progress(byte_ip),
        .async_ppp_mode(ppp), .tx_idle_ones(idle1), .tx_bit(tx_bit),
        .tx_clk_int(tclk_int), .tx_slot_mark(slot), .irq_events(irq_ev),
        .line_coding_select(lcs), .protocol_engine_select(pes),
        .clock_mode_select(cms), .bus_config_mode(busm), .clk_option_b(optb),
        .dpll_no_shift(noshift), .sample_x16(x16), .high_speed_path(hsp),
        .tx_enable(tx_en), .rx_enable(rx_en), .rx_bit(rx_bit), .cd_level(cdl),
        .irq_vector(vec), .cts_n_pin(cts_pin), .cd_pin(cd_pin),
        .rxd_pin(rxd_pin), .tx_clock_pin_in(tclk), .tx_clock_pin_out(tco),
        .tx_clock_pin_oe_n(tco_oe_n), .rts_n_pin_out(rts_o),
        .rts_n_pin_oe_n(rts_oe_n), .txd_pin_out(txd_o), .txd_pin_oe_n(txd_oe_n));

    sccfg_remote far (.run(run), .cts_n(cts_n), .cd(cd), .rxd(rxd),
        .txd_out(txd_o), .txd_oe_n(txd_oe_n), .cts_n_pin(cts_pin),
        .cd_pin(cd_pin), .rxd_pin(rxd_pin), .tclk(tclk), .line(line));

    // 200 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard, well above the expected run length
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic bus_exp(input logic [2:0] sc);
        return (sc == 3'h1) || (sc == 3'h3);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; holds until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 100)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n == 100)
            bad_count++;
        rdat = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // long enough for pin syncs and a few link clock edges
    task automatic settle;
        repeat (40) @(posedge core_clk);
    endtask

    task automatic cfg(input logic [31:0] z, input logic [31:0] o);
        apb(1'b1, CFG_ZERO_OFS, z);
        apb(1'b1, CFG_ONE_OFS, o);
        settle();
    endtask

    // one event pulse, then count vector cycles
    task automatic pulse(input logic [7:0] e);
        c = '0;
        @(posedge core_clk);
        irq_ev <= e;
        @(posedge core_clk);
        irq_ev <= 8'h00;
        repeat (4)
        begin
            @(posedge core_clk);
            c = c + vec;
        end
    endtask

    task automatic summarize;
        $display("checks=%0d bad=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, irq_ev} = '0;
        {tx_act, rx_act, fifo, sh_empty, at_thr, byte_ip, ppp} = '0;
        {idle1, tx_bit, tclk_int, slot, run, cd, rxd, cts_n} = '0;
        reset = 1'b1;
        seed = 14;
        bad_count = 0;
        n_checks = 0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        // reset values and an unmapped place
        apb(1'b0, CFG_ZERO_OFS, 0);
        chk(rdat, CFG_RST);
        apb(1'b0, CFG_ONE_OFS, 0);
        chk(rdat, CFG_RST);
        apb(1'b0, 12'h100, 0);
        chk(rdat, 32'h0);
        chk(err, 1);
        // random configs, every line code visited
        for (i = 0; i < 24; i++)
        begin
            v = $random(seed);
            v[18:16] = i[2:0];
            v[21:20] = eng_tab[i % 3];
            apb(1'b1, CFG_ZERO_OFS, v);
            apb(1'b0, CFG_ZERO_OFS, 0);
            chk(rdat, v & Z_WMASK);
            chk(lcs, v[18:16]);
            chk(busm, bus_exp(v[18:16]));
            chk(pes, v[21:20]);
            chk(cms, v[2:0]);
            // codes 0 to 3 all carry nrz or nrzi bits, bus modes included
            chk(noshift, v[8] && !v[18]);
        end
        // transmit clock pin: mode 0b clock, mode 5 marker, off
        tclk_int <= 1'b1;
        cfg(32'h30, 0);
        chk({optb, tco_oe_n, tco}, 3'b101);
        tclk_int <= 1'b0;
        slot <= 1'b1;
        cfg(32'h25, 0);
        chk({tco_oe_n, tco}, 2'b01);
        cfg(32'h05, 0);
        chk(tco_oe_n, 1);
        // async sampling rate, non dpll clock mode
        cfg(32'h30_0080, 0);
        chk(x16, 1);
        cfg(32'h30_0000, 0);
        chk(x16, 0);
        // high speed: clock on request pin
        tclk_int <= 1'b1;
        cfg(32'h0c, 32'h0100_0000);
        chk({hsp, rts_oe_n, rts_o}, 3'b101);
        cfg(32'h0c, 0);
        chk(rts_oe_n, 1);
        // inversion on push-pull nrz, idle ones kept
        rxd <= 1'b1;
        cfg(0, 32'h0201_0000);
        chk({txd_oe_n, txd_o, rx_bit}, 3'b010);
        idle1 <= 1'b1;
        tx_bit <= 1'b1;
        settle();
        chk(txd_o, 1);
        // outside hdlc the idle ones are inverted like any bit
        cfg(32'h30_0000, 32'h0201_0000);
        chk(txd_o, 0);
        idle1 <= 1'b0;
        cfg(0, 0);
        chk({txd_oe_n, line}, 2'b11);
        tx_bit <= 1'b0;
        settle();
        chk({txd_oe_n, line}, 2'b00);
        // carrier auto start, clock mode 0 keeps it legal
        cd <= 1'b1;
        cfg(0, 32'h0004_0000);
        chk({rx_en, cdl}, 2'b11);
        cd <= 1'b0;
        settle();
        chk({rx_en, cdl}, 2'b00);
        cfg(0, 32'h0006_0000);
        chk({rx_en, cdl}, 2'b10);
        // clear-to-send gating, then a byte in flight
        cts_n <= 1'b1;
        cfg(0, 0);
        chk(tx_en, 0);
        cfg(0, 32'h0008_0000);
        chk(tx_en, 1);
        cts_n <= 1'b0;
        byte_ip <= 1'b1;
        cfg(32'h30_0000, 0);
        cts_n <= 1'b1;
        settle();
        chk(tx_en, 1);
        byte_ip <= 1'b0;
        settle();
        chk(tx_en, 0);
        // request pin needs the link clock: one long frame
        run <= 1'b1;
        tx_act <= 1'b1;
        cfg(0, 0);
        chk(rts_o, 0);
        tx_act <= 1'b0;
        cfg(0, 32'h0020_0000);
        chk(rts_o, 0);
        fifo <= 1'b1;
        cfg(32'h30_0000, 0);
        chk(rts_o, 0);
        fifo <= 1'b0;
        cfg(32'h30_0000, 32'h0030_0000);
        chk(rts_o, 1);
        sh_empty <= 1'b1;
        cfg(32'h30_0000, 32'h0010_0000);
        chk(rts_o, 0);
        sh_empty <= 1'b0;
        at_thr <= 1'b1;
        settle();
        chk(rts_o, 1);
        cfg(32'h01_0000, 32'h0080_0000);
        chk(rts_o, 1);
        rx_act <= 1'b1;
        cfg(32'h01_0000, 32'h00c0_0000);
        chk(rts_o, 0);
        run <= 1'b0;
        // masked source: no vector, hidden until visible
        apb(1'b1, IRQ_MASK_OFS, 32'h1);
        cfg(0, 0);
        pulse(8'h01);
        chk(c, 0);
        pulse(8'h02);
        chk(c, 1);
        apb(1'b0, IRQ_STAT_OFS, 0);
        chk(rdat, 32'h2);
        apb(1'b1, CFG_ZERO_OFS, 32'h1000);
        apb(1'b0, IRQ_STAT_OFS, 0);
        chk(rdat, 32'h1);
        apb(1'b0, IRQ_STAT_OFS, 0);
        chk(rdat, 32'h0);
        summarize();
    end
endmodule
